//--- sirq_defs.svh
// Offsets, field positions, reset values and address-map bounds of the system interrupt registers
`ifndef SIRQ_DEFS_SVH
`define SIRQ_DEFS_SVH

// Register offsets
`define SIRQ_OFS_EN1        16'h0000
`define SIRQ_OFS_EN2        16'h0001
`define SIRQ_OFS_FLG1       16'h0002
`define SIRQ_OFS_FLG2       16'h0003

// Enable register bits
`define SIRQ_EN_WDOG        0
`define SIRQ_EN_OSC         1
`define SIRQ_EN_NMI         4
`define SIRQ_EN_FLASH       5
`define SIRQ_EN1_MASK       8'h33
`define SIRQ_EN1_RST        8'h00

// Flag register bits
`define SIRQ_FL_WDOG        0
`define SIRQ_FL_OSC         1
`define SIRQ_FL_POR         2
`define SIRQ_FL_PIN         3
`define SIRQ_FL_NMI         4
`define SIRQ_FLG1_MASK      8'h1f
`define SIRQ_FL_OSC_RST     1'b1
`define SIRQ_FL_NMI_RST     1'b0
`define SIRQ_FL_WDOG_RST    1'b0
`define SIRQ_FL_POR_RST     1'b1
`define SIRQ_FL_PIN_RST     1'b0

// Address map
`define SIRQ_SFR_TOP        16'h000f
`define SIRQ_BYTE_TOP       16'h00ff
`define SIRQ_WORD_TOP       16'h01ff
`define SIRQ_RAM_BASE       16'h0200
`define SIRQ_RAM_TOP        16'h027f
`define SIRQ_INFO_BASE      16'h1000
`define SIRQ_INFO_TOP       16'h10ff
`define SIRQ_CODE_BASE      16'hf800
`define SIRQ_SPARE_VEC_LO   16'hffc0
`define SIRQ_SPARE_VEC_HI   16'hffdf

// Vector addresses
`define SIRQ_VEC_RESET      16'hfffe
`define SIRQ_VEC_NMI        16'hfffc

`endif

//--- sirq_pkg.sv
// Types shared by the system interrupt register bank
package sirq_pkg;

	typedef enum logic [1:0] {
		SIRQ_REG_NONE,
		SIRQ_REG_SFR,
		SIRQ_REG_BYTE,
		SIRQ_REG_WORD
	} sirq_region_t;

	typedef struct packed {
		logic         region_ok;
		logic         fetch_bad;
		logic         width_bad;
		sirq_region_t region;
	} sirq_decode_t;

	typedef struct packed {
		logic wdog_overflow;
		logic wdog_key_bad;
		logic osc_fault;
		logic pin_nmi;
		logic pin_reset;
	} sirq_events_t;

endpackage

//--- sirq_addr_decode.sv
// Address-map decoder: region of an access, bad fetches and wrong access width
`include "sirq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sirq_addr_decode (
	// Access
	input  wire logic [15:0]            addr,
	input  wire logic                   fetch,
	input  wire logic                   byte_acc,
	// Result
	output sirq_pkg::sirq_decode_t      dec
);

	wire logic in_sfr;
	wire logic in_byte;
	wire logic in_word;
	wire logic in_ram;
	wire logic in_info;
	wire logic in_code;
	wire logic in_periph;

	assign in_sfr    = (addr <= `SIRQ_SFR_TOP); // RL12
	assign in_byte   = (addr > `SIRQ_SFR_TOP) && (addr <= `SIRQ_BYTE_TOP); // RL12
	assign in_word   = (addr > `SIRQ_BYTE_TOP) && (addr <= `SIRQ_WORD_TOP); // RL12
	assign in_ram    = (addr >= `SIRQ_RAM_BASE) && (addr <= `SIRQ_RAM_TOP);
	assign in_info   = (addr >= `SIRQ_INFO_BASE) && (addr <= `SIRQ_INFO_TOP);
	// Spare vector words lie inside code flash, so fetches there are legal
	assign in_code   = (addr >= `SIRQ_CODE_BASE); // RL3
	assign in_periph = in_sfr | in_byte | in_word;

	assign dec.region    = in_sfr  ? sirq_pkg::SIRQ_REG_SFR  :
	                       in_byte ? sirq_pkg::SIRQ_REG_BYTE :
	                       in_word ? sirq_pkg::SIRQ_REG_WORD : sirq_pkg::SIRQ_REG_NONE;
	assign dec.region_ok = in_periph | in_ram | in_info | in_code;
	assign dec.fetch_bad = fetch & (in_periph | ~(in_ram | in_info | in_code)); // RL1
	// Flags a master breaking its access width; the bank itself still answers
	assign dec.width_bad = ~fetch & ((in_word & byte_acc) | ((in_sfr | in_byte) & ~byte_acc)); // RL13

endmodule

`default_nettype wire

//--- sirq_regs.sv
// System interrupt enable and flag registers with address-map reset decode
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: Instruction fetch from peripheral space 0h-01FFh or unused space raises a reset.
// RL2: Pin NMI, oscillator fault, flash violation gated by own enable only, not GIE.
// RL3: Unused vector words 0xFFC0-0xFFDE are plain code memory, no source mapped.
// RL4: Unassigned special function bits have no storage.
// RL5: Bits are read/write; some reset on soft reset, others only on power-on.
// RL6: Enable register 00h: flash bit5, NMI bit4, osc bit1, watchdog bit0; soft reset clears.
// RL7: Watchdog enable acts only in interval-timer mode, not in watchdog mode.
// RL8: Watchdog flag sets on overflow in watchdog mode or on a bad key write.
// RL9: Watchdog flag clears on power-on and on a pin reset in reset function.
// RL10: Flag register 02h: NMI bit4, pin reset bit3, power-on bit2, osc bit1, watchdog bit0.
// RL11: Pin-reset flag sets on pin reset in reset function, clears on power-up.
// RL12: Decode SFRs at 0x0-0xF, byte peripherals to 0xFF, word peripherals to 0x1FF.
// RL13: Master uses byte access for SFR/byte area, word access for word area.
// RL14: Power-up, pin reset, watchdog share top vector; NMI class shares the next.
// RL15: Unimplemented bits read zero and ignore writes.
//////////////////////////////////////////////////////////////////////////////
`include "sirq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sirq_regs (
	// Clock and resets
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   soft_reset,
	// CPU register access
	input  wire logic [15:0]            addr,
	input  wire logic                   wr_en,
	input  wire logic                   rd_en,
	input  wire logic                   fetch,
	input  wire logic                   byte_acc,
	input  wire logic [7:0]             wdata,
	output logic      [7:0]             rdata,
	// Peripheral events
	input  wire sirq_pkg::sirq_events_t events,
	input  wire logic                   wdog_interval_mode,
	input  wire logic                   pin_reset_mode,
	input  wire logic                   flash_violation_flag,
	input  wire logic                   gie,
	input  wire logic                   wdog_interval_irq,
	// Requests to the core
	output logic                        fetch_reset_req,
	output logic                        access_width_err,
	output logic                        reset_vec_req,
	output logic                        nmi_vec_req,
	output logic                        wdog_irq_req,
	output logic      [15:0]            vector_addr
);

	//////////////////////////////////////////////////////////////////////////
	// Decode

	sirq_pkg::sirq_decode_t dec;

	sirq_addr_decode u_dec (
		.addr     (addr),
		.fetch    (fetch),
		.byte_acc (byte_acc),
		.dec      (dec)
	);

	wire logic in_sfr_area;
	wire logic hit_en1;
	wire logic hit_flg1;
	wire logic wr_en1;
	wire logic wr_flg1;

	// Second enable and flag registers hold no bits, so nothing decodes them and they read zero
	assign in_sfr_area = (dec.region == sirq_pkg::SIRQ_REG_SFR); // RL12
	assign hit_en1     = in_sfr_area & (addr == `SIRQ_OFS_EN1);
	assign hit_flg1    = in_sfr_area & (addr == `SIRQ_OFS_FLG1);
	assign wr_en1      = wr_en & hit_en1;
	assign wr_flg1     = wr_en & hit_flg1;

	//////////////////////////////////////////////////////////////////////////
	// Storage: only assigned bits exist

	logic watchdog_irq_en_r;
	logic osc_fault_irq_en_r;
	logic pin_nmi_irq_en_r;
	logic flash_violation_irq_en_r;
	logic watchdog_flag_r;
	logic osc_fault_flag_r;
	logic power_on_flag_r;
	logic pin_reset_flag_r;
	logic pin_nmi_flag_r;

	wire logic wdog_set;
	wire logic pin_rst_evt;

	assign wdog_set    = (events.wdog_overflow & ~wdog_interval_mode) | events.wdog_key_bad; // RL8
	assign pin_rst_evt = events.pin_reset & pin_reset_mode;

	wire logic [7:0] wd_en;
	wire logic [7:0] wd_fl;
	assign wd_en = wdata & `SIRQ_EN1_MASK; // RL15
	assign wd_fl = wdata & `SIRQ_FLG1_MASK; // RL15

	//////////////////////////////////////////////////////////////////////////
	// Next values: hardware set is OR-ed after the write mux so it beats a write clear

	wire logic watchdog_irq_en_nxt;
	wire logic osc_fault_irq_en_nxt;
	wire logic pin_nmi_irq_en_nxt;
	wire logic flash_violation_irq_en_nxt;
	wire logic watchdog_flag_nxt;
	wire logic osc_fault_flag_nxt;
	wire logic power_on_flag_nxt;
	wire logic pin_reset_flag_nxt;
	wire logic pin_nmi_flag_nxt;

	assign watchdog_irq_en_nxt        = wr_en1 ? wd_en[`SIRQ_EN_WDOG] : watchdog_irq_en_r; // RL5
	assign osc_fault_irq_en_nxt       = wr_en1 ? wd_en[`SIRQ_EN_OSC] : osc_fault_irq_en_r;
	assign pin_nmi_irq_en_nxt         = wr_en1 ? wd_en[`SIRQ_EN_NMI] : pin_nmi_irq_en_r;
	assign flash_violation_irq_en_nxt = wr_en1 ? wd_en[`SIRQ_EN_FLASH] : flash_violation_irq_en_r;
	// A pin reset forces the watchdog flag clear over any other cause
	assign watchdog_flag_nxt  = ~pin_rst_evt &
	                            (wdog_set | (wr_flg1 ? wd_fl[`SIRQ_FL_WDOG] : watchdog_flag_r)); // RL9
	assign osc_fault_flag_nxt = events.osc_fault |
	                            (wr_flg1 ? wd_fl[`SIRQ_FL_OSC] : osc_fault_flag_r);
	assign power_on_flag_nxt  = wr_flg1 ? wd_fl[`SIRQ_FL_POR] : power_on_flag_r; // RL5
	assign pin_reset_flag_nxt = pin_rst_evt |
	                            (wr_flg1 ? wd_fl[`SIRQ_FL_PIN] : pin_reset_flag_r); // RL11
	assign pin_nmi_flag_nxt   = events.pin_nmi |
	                            (wr_flg1 ? wd_fl[`SIRQ_FL_NMI] : pin_nmi_flag_r); // RL10

	// Enables: soft reset class, cleared by either reset
	always_ff @(posedge clk) begin
		if (sys_rst || soft_reset) begin
			watchdog_irq_en_r        <= 1'b0; // RL6
			osc_fault_irq_en_r       <= 1'b0; // RL6
			pin_nmi_irq_en_r         <= 1'b0; // RL6
			flash_violation_irq_en_r <= 1'b0; // RL6
		end else begin
			watchdog_irq_en_r        <= watchdog_irq_en_nxt;
			osc_fault_irq_en_r       <= osc_fault_irq_en_nxt;
			pin_nmi_irq_en_r         <= pin_nmi_irq_en_nxt;
			flash_violation_irq_en_r <= flash_violation_irq_en_nxt;
		end
	end

	// Soft reset class flags
	always_ff @(posedge clk) begin
		if (sys_rst || soft_reset) begin
			osc_fault_flag_r <= `SIRQ_FL_OSC_RST; // RL5
			pin_nmi_flag_r   <= `SIRQ_FL_NMI_RST;
		end else begin
			osc_fault_flag_r <= osc_fault_flag_nxt;
			pin_nmi_flag_r   <= pin_nmi_flag_nxt;
		end
	end

	// Power-on class flags: soft reset leaves them alone
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			watchdog_flag_r  <= `SIRQ_FL_WDOG_RST; // RL9
			power_on_flag_r  <= `SIRQ_FL_POR_RST; // RL10
			pin_reset_flag_r <= `SIRQ_FL_PIN_RST; // RL11
		end else begin
			watchdog_flag_r  <= watchdog_flag_nxt;
			power_on_flag_r  <= power_on_flag_nxt;
			pin_reset_flag_r <= pin_reset_flag_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read-back and requests

	wire logic [7:0] en1_view;
	wire logic [7:0] flg1_view;
	wire logic [7:0] rd_nxt;

	assign en1_view  = {2'b00, flash_violation_irq_en_r, pin_nmi_irq_en_r,
	                    2'b00, osc_fault_irq_en_r, watchdog_irq_en_r}; // RL4
	assign flg1_view = {3'b000, pin_nmi_flag_r, pin_reset_flag_r, power_on_flag_r,
	                    osc_fault_flag_r, watchdog_flag_r}; // RL15
	assign rd_nxt    = !rd_en    ? 8'h00 :
	                   hit_en1   ? en1_view :
	                   hit_flg1  ? flg1_view : 8'h00; // RL15

	wire logic nmi_class;
	wire logic reset_class;
	wire logic wdog_irq;

	// Non-maskable class ignores the global enable
	assign nmi_class   = (pin_nmi_flag_r & pin_nmi_irq_en_r) |
	                     (osc_fault_flag_r & osc_fault_irq_en_r) |
	                     (flash_violation_flag & flash_violation_irq_en_r); // RL2
	// A bad fetch asks for reset at once; no flag keeps a record of it
	assign reset_class = (power_on_flag_r | pin_reset_flag_r) | (watchdog_flag_r & ~wdog_interval_mode)
	                     | dec.fetch_bad; // RL14
	// Interval interrupt uses the enable only in timer mode
	assign wdog_irq    = wdog_interval_mode & watchdog_irq_en_r & wdog_interval_irq & gie; // RL7

	wire logic        width_err_nxt;
	wire logic [15:0] vector_nxt;

	// Width faults are reported only; the access itself still completes
	assign width_err_nxt = (rd_en | wr_en) & dec.width_bad; // RL13
	assign vector_nxt    = reset_class ? `SIRQ_VEC_RESET :
	                       nmi_class   ? `SIRQ_VEC_NMI : 16'h0000; // RL14

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata            <= 8'h00;
			fetch_reset_req  <= 1'b0;
			access_width_err <= 1'b0;
			reset_vec_req    <= 1'b0;
			nmi_vec_req      <= 1'b0;
			wdog_irq_req     <= 1'b0;
			vector_addr      <= 16'h0000;
		end else begin
			rdata            <= rd_nxt;
			fetch_reset_req  <= dec.fetch_bad; // RL1
			access_width_err <= width_err_nxt;
			reset_vec_req    <= reset_class; // RL14
			nmi_vec_req      <= nmi_class; // RL14
			wdog_irq_req     <= wdog_irq; // RL7
			vector_addr      <= vector_nxt;
		end
	end

endmodule

`default_nettype wire

//--- sirq_regs_assertions.sv
// Port-level assertions for the system interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module sirq_regs_assertions (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   sys_rst,
	// Access
	input wire logic [15:0]            addr,
	input wire logic                   rd_en,
	input wire logic                   wr_en,
	input wire logic                   byte_acc,
	input wire logic                   fetch,
	input wire logic [7:0]             rdata,
	// Events and modes
	input wire sirq_pkg::sirq_events_t events,
	input wire logic                   wdog_interval_mode,
	input wire logic                   pin_reset_mode,
	input wire logic                   gie,
	// Requests
	input wire logic                   fetch_reset_req,
	input wire logic                   access_width_err,
	input wire logic                   reset_vec_req,
	input wire logic                   nmi_vec_req,
	input wire logic                   wdog_irq_req,
	input wire logic [15:0]            vector_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_fetch_low_rst: assert property (fetch && addr <= 16'h01ff |=> fetch_reset_req)
		else $error("fetch from register space gave no reset");
	a_fetch_ram_ok: assert property (fetch && addr inside {[16'h0200:16'h027f]} |=> !fetch_reset_req)
		else $error("fetch from data memory gave a reset");
	a_spare_vec_code: assert property (fetch && addr inside {[16'hffc0:16'hffdf]} |=> !fetch_reset_req)
		else $error("fetch from spare vector words gave a reset");
	a_wdog_irq_mode: assert property (wdog_irq_req |-> $past(wdog_interval_mode) && $past(gie))
		else $error("watchdog request outside interval mode");
	a_reset_vec_addr: assert property (reset_vec_req |-> vector_addr == 16'hfffe)
		else $error("reset class without top vector");
	a_nmi_vec_addr: assert property (nmi_vec_req && !reset_vec_req |-> vector_addr == 16'hfffc)
		else $error("nmi class without next vector");
	a_idle_vec_zero: assert property (!nmi_vec_req && !reset_vec_req |-> vector_addr == 16'h0000)
		else $error("vector without request");
	a_unused_rd_zero: assert property (rd_en && addr == 16'h0001 |=> rdata == 8'h00)
		else $error("unused register read not zero");
	a_en_read_mask: assert property (rd_en && addr == 16'h0000 |=> (rdata & 8'hcc) == 8'h00)
		else $error("absent enable bit read as one");
	a_pin_rst_vec: assert property (events.pin_reset && pin_reset_mode |-> ##2 reset_vec_req)
		else $error("pin reset gave no reset request");
	a_word_area_width: assert property ((rd_en || wr_en) && !fetch && byte_acc && addr >= 16'h0100 && addr <= 16'h01ff |=> access_width_err)
		else $error("byte access to word area not reported");
endmodule
`default_nettype wire

//--- sirq_cpu_model.sv
// Behavioural CPU core driving the register bank's access port
`timescale 1ns/1ps
`default_nettype none
module sirq_cpu_model (
	// Clock
	input  wire logic       clk,
	// Access
	output var logic [15:0] addr,
	output var logic        wr_en,
	output var logic        rd_en,
	output var logic        fetch,
	output var logic        byte_acc,
	output var logic [7:0]  wdata
);
	initial begin
		{wr_en, rd_en, fetch, byte_acc} = 4'h0;
		addr = 16'h0400;
		wdata = 8'h00;
	end
	// One access held for one edge; on release the strobes drop, address and data show the inverse, and byte_acc keeps its value
	task automatic go(input logic [15:0] a, input logic [7:0] d, input logic w, r, f);
		@(negedge clk);
		addr = a;
		wdata = d;
		{wr_en, rd_en, fetch} = {w, r, f};
		byte_acc = !f && a <= 16'h00ff;
		@(negedge clk);
		{wr_en, rd_en, fetch} = 3'h0;
		addr = ~addr;
		wdata = ~wdata;
	endtask
	// Breaks the width rule on purpose, so the bank's width report can be seen
	task automatic go_bad_width(input logic [15:0] a);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		byte_acc = a > 16'h00ff;
		@(negedge clk);
		rd_en = 1'b0;
		addr = ~addr;
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the system interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, sys_rst = 1'b1, soft_reset = 1'b0, rd_en, wr_en, fetch, byte_acc;
	logic wdog_interval_mode = 1'b0, pin_reset_mode = 1'b1, gie = 1'b0, wdog_interval_irq = 1'b0;
	logic flash_violation_flag = 1'b0;
	logic fetch_reset_req, access_width_err, reset_vec_req, nmi_vec_req, wdog_irq_req;
	logic [15:0] addr, vector_addr;
	logic [7:0] wdata, rdata;
	sirq_pkg::sirq_events_t events = '0;
	int mismatches = 0, comparisons = 0, cycles = 0;
	always #12.5 clk = ~clk;
	sirq_cpu_model u_cpu (.clk, .addr, .wr_en, .rd_en, .fetch, .byte_acc, .wdata);
	sirq_regs u_dut (.clk, .sys_rst, .soft_reset, .addr, .wr_en, .rd_en, .fetch, .byte_acc,
		.wdata, .rdata, .events, .wdog_interval_mode, .pin_reset_mode,
		.flash_violation_flag, .gie, .wdog_interval_irq, .fetch_reset_req,
		.access_width_err, .reset_vec_req, .nmi_vec_req, .wdog_irq_req, .vector_addr);
	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (mismatches == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		u_cpu.go(a, 8'h00, 1'b0, 1'b1, 1'b0);
		chk("rdata", {8'h00, e}, {8'h00, rdata});
	endtask
	// Pulse one event, then let the request register catch up
	task automatic pulse(input int b);
		@(negedge clk) events[b] = 1'b1;
		@(negedge clk) events = '0;
		@(negedge clk);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdc(16'h0002, 8'h06);
		rdc(16'h0000, 8'h00);
		chk("vector", 16'hfffe, vector_addr);
		u_cpu.go(16'h0000, 8'hff, 1'b1, 1'b0, 1'b0);
		rdc(16'h0000, 8'h33);
		u_cpu.go(16'h0001, 8'hff, 1'b1, 1'b0, 1'b0);
		rdc(16'h0001, 8'h00);
		u_cpu.go(16'h0002, 8'he0, 1'b1, 1'b0, 1'b0);
		rdc(16'h0002, 8'h00);
		chk("vector", 16'h0000, vector_addr);
	endtask
	task automatic t_nmi;
		pulse(1);
		chk("nmi", 16'h0001, {15'h0, nmi_vec_req});
		chk("vector", 16'hfffc, vector_addr);
		rdc(16'h0002, 8'h10);
		u_cpu.go(16'h0002, 8'h00, 1'b1, 1'b0, 1'b0);
		pulse(2);
		chk("nmi", 16'h0001, {15'h0, nmi_vec_req});
		u_cpu.go(16'h0002, 8'h00, 1'b1, 1'b0, 1'b0);
		@(negedge clk) flash_violation_flag = 1'b1;
		repeat (2) @(negedge clk);
		chk("nmi", 16'h0001, {15'h0, nmi_vec_req});
		chk("vector", 16'hfffc, vector_addr);
		@(negedge clk) flash_violation_flag = 1'b0;
	endtask
	task automatic t_wdog;
		@(negedge clk) {wdog_interval_mode, gie, wdog_interval_irq} = 3'h7;
		repeat (2) @(negedge clk);
		chk("wdog", 16'h0001, {15'h0, wdog_irq_req});
		pulse(4);
		rdc(16'h0002, 8'h00);
		@(negedge clk) wdog_interval_mode = 1'b0;
		repeat (2) @(negedge clk);
		chk("wdog", 16'h0000, {15'h0, wdog_irq_req});
		pulse(4);
		rdc(16'h0002, 8'h01);
		chk("reset", 16'h0001, {15'h0, reset_vec_req});
		pulse(0);
		rdc(16'h0002, 8'h08);
		pulse(3);
		rdc(16'h0002, 8'h09);
		@(negedge clk) pin_reset_mode = 1'b0;
		pulse(0);
		rdc(16'h0002, 8'h09);
		pin_reset_mode = 1'b1;
	endtask
	task automatic t_soft;
		@(negedge clk) soft_reset = 1'b1;
		@(negedge clk) soft_reset = 1'b0;
		rdc(16'h0000, 8'h00);
		rdc(16'h0002, 8'h0b);
	endtask
	task automatic t_por;
		@(negedge clk) sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		rdc(16'h0002, 8'h06);
		rdc(16'h0000, 8'h00);
		chk("vector", 16'hfffe, vector_addr);
	endtask
	task automatic t_fetch;
		logic [15:0] a[5] = '{16'h0000, 16'h01ff, 16'h0200, 16'hffc0, 16'h0300};
		logic e[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			u_cpu.go(a[i], 8'h00, 1'b0, 1'b0, 1'b1);
			chk("fetch", {15'h0, e[i]}, {15'h0, fetch_reset_req});
		end
	endtask
	task automatic t_width;
		u_cpu.go_bad_width(16'h0120);
		chk("width", 16'h0001, {15'h0, access_width_err});
		u_cpu.go_bad_width(16'h0002);
		chk("width", 16'h0001, {15'h0, access_width_err});
		rdc(16'h0120, 8'h00);
		chk("width", 16'h0000, {15'h0, access_width_err});
	endtask
	//////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		t_regs();
		t_nmi();
		t_wdog();
		t_soft();
		t_por();
		t_fetch();
		t_width();
		summarize();
	end
endmodule
bind sirq_regs sirq_regs_assertions u_chk (.clk, .sys_rst, .addr, .rd_en, .wr_en, .byte_acc,
	.fetch, .rdata, .events, .wdog_interval_mode, .pin_reset_mode, .gie, .fetch_reset_req,
	.access_width_err, .reset_vec_req, .nmi_vec_req, .wdog_irq_req, .vector_addr);
`default_nettype wire
